/* File: vipi_delivery.v */
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "vipi_map.vh"
module vipi_delivery #(
	parameter PA_BITS = 48
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Avalon-MM slave
	input wire [5:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// System memory
	output wire mem_req_o,
	output wire mem_we_o,
	output reg mem_lock_o,
	output wire [51:0] mem_addr_o,
	output wire [63:0] mem_wdata_o,
	input wire [63:0] mem_rdata_i,
	input wire mem_ack_i,
	// Doorbells
	output reg db_valid_o,
	output reg [11:0] db_core_o,
	output reg db_self_o,
	// Guest exit
	output reg guest_exit_o,
	output reg [3:0] exit_code_o
);
	localparam S_IDLE = 4'd0;
	localparam S_ENTRY = 4'd1;
	localparam S_DECODE = 4'd2;
	localparam S_LOG = 4'd3;
	localparam S_LOG_WAIT = 4'd4;
	localparam S_PHY = 4'd5;
	localparam S_PHY_WAIT = 4'd6;
	localparam S_IRR_RD = 4'd7;
	localparam S_IRR_WR = 4'd8;
	localparam S_IRR_WAIT = 4'd9;
	localparam S_NEXT = 4'd10;
	localparam S_FINISH = 4'd11;
	localparam S_EXIT = 4'd12;

	localparam K_DIRECT = 2'd0;
	localparam K_BCAST = 2'd1;
	localparam K_LOGIC = 2'd2;
	localparam K_SELF = 2'd3;

	// Pointer lies inside the supported physical range
	function ptr_ok;
		input [51:0] p;
		begin
			ptr_ok = ((p >> PA_BITS) == 52'h0);
		end
	endfunction

	// Byte-lane merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wval;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					merge[i*8 +: 8] = wval[i*8 +: 8];
				end
			end
		end
	endfunction

	reg [2:0] ctrl_r;
	reg [8:0] own_id_r;
	reg [51:0] ptr_back_r;
	reg [51:0] ptr_log_r;
	reg [51:0] ptr_phy_r;
	reg [31:0] cmd_lo_r;
	reg [31:0] cmd_hi_r;
	reg exit_flag_r;
	reg [63:0] exit_detail_r;
	reg running_r;
	reg ack_r;
	reg [3:0] state_r;
	reg [1:0] kind_r;
	reg excl_r;
	reg [8:0] idx_r;
	reg [3:0] pos_r;
	reg log_hi_r;
	reg [51:12] bp_r;
	reg sched_r;
	reg [11:0] core_r;
	reg unsched_r;
	reg [3:0] code_r;
	reg mp_start_r;
	reg mp_we_r;
	reg [51:0] mp_addr_r;
	reg [63:0] mp_wdata_r;

	wire mp_done;
	wire [63:0] mp_rdata;
	wire dg_hit;
	wire dg_bad;
	wire [11:0] dg_off;
	wire [8:0] dg_phys;

	wire busy = (state_r != S_IDLE);
	wire reg_mode = ctrl_r[`VIPI_CTRL_REGMODE];
	wire [11:0] max_idx = ptr_phy_r[11:0];
	wire [7:0] vec = cmd_lo_r[7:0];
	wire [31:0] log_ent = log_hi_r ? mp_rdata[63:32] : mp_rdata[31:0];
	wire [11:0] irr_off = `VIPI_IRR_BASE | {5'h00, vec[7:5], 4'h0};

	// Avalon handshake, command and entry writes stall while a command runs
	wire req = avs_read_i || avs_write_i;
	wire stall = avs_write_i && busy &&
		(avs_address_i == `VIPI_CMD_LO || avs_address_i == `VIPI_CTRL);
	assign avs_waitrequest_o = req && !ack_r;
	wire wr_acc = avs_write_i && ack_r;
	wire wr_cmd = wr_acc && (avs_address_i == `VIPI_CMD_LO);
	wire wr_enter = wr_acc && (avs_address_i == `VIPI_CTRL) && avs_byteenable_i[0] &&
		avs_writedata_i[`VIPI_CTRL_ENTER];
	wire clr_exit = wr_acc && (avs_address_i == `VIPI_STATUS) && avs_byteenable_i[0] &&
		avs_writedata_i[`VIPI_ST_EXIT];
	wire [31:0] ctrl_m = merge({30'h0, ctrl_r[1:0]}, avs_writedata_i, avs_byteenable_i);
	wire [31:0] own_m = merge({23'h0, own_id_r}, avs_writedata_i, avs_byteenable_i);
	wire [31:0] back_m = merge({12'h0, ptr_back_r[51:32]}, avs_writedata_i, avs_byteenable_i);
	wire [31:0] log_m = merge({12'h0, ptr_log_r[51:32]}, avs_writedata_i, avs_byteenable_i);
	wire [31:0] phy_m = merge({12'h0, ptr_phy_r[51:32]}, avs_writedata_i, avs_byteenable_i);

	vipi_mem_port u_mem_port (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(mp_start_r),
		.we_i(mp_we_r),
		.addr_i(mp_addr_r),
		.wdata_i(mp_wdata_r),
		.done_o(mp_done),
		.rdata_o(mp_rdata),
		.mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i)
	);

	vipi_dest_gen u_dest_gen (
		.reg_mode_i(reg_mode),
		.cluster_i(ctrl_r[`VIPI_CTRL_CLUSTER]),
		.dest_i(cmd_hi_r),
		.pos_i(pos_r),
		.hit_o(dg_hit),
		.bad_o(dg_bad),
		.log_off_o(dg_off),
		.phys_idx_o(dg_phys)
	);

	// Register file and bus answer
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			avs_readdata_o <= `VIPI_RST_32;
			ctrl_r <= 3'h0;
			own_id_r <= 9'h000;
			ptr_back_r <= 52'h0;
			ptr_log_r <= 52'h0;
			ptr_phy_r <= 52'h0;
			cmd_lo_r <= `VIPI_RST_32;
			cmd_hi_r <= `VIPI_RST_32;
		end else begin
			ack_r <= req && !ack_r && !stall;
			if (req && !ack_r && !stall) begin
				if (avs_address_i == `VIPI_CTRL) begin
					avs_readdata_o <= {29'h0, 1'b0, ctrl_r[1:0]};
				end else if (avs_address_i == `VIPI_OWN_ID) begin
					avs_readdata_o <= {23'h0, own_id_r};
				end else if (avs_address_i == `VIPI_BACK_LO) begin
					avs_readdata_o <= ptr_back_r[31:0];
				end else if (avs_address_i == `VIPI_BACK_HI) begin
					avs_readdata_o <= {12'h0, ptr_back_r[51:32]};
				end else if (avs_address_i == `VIPI_LOG_LO) begin
					avs_readdata_o <= ptr_log_r[31:0];
				end else if (avs_address_i == `VIPI_LOG_HI) begin
					avs_readdata_o <= {12'h0, ptr_log_r[51:32]};
				end else if (avs_address_i == `VIPI_PHY_LO) begin
					avs_readdata_o <= ptr_phy_r[31:0];
				end else if (avs_address_i == `VIPI_PHY_HI) begin
					avs_readdata_o <= {12'h0, ptr_phy_r[51:32]};
				end else if (avs_address_i == `VIPI_CMD_LO) begin
					avs_readdata_o <= cmd_lo_r;
				end else if (avs_address_i == `VIPI_CMD_HI) begin
					avs_readdata_o <= cmd_hi_r;
				end else if (avs_address_i == `VIPI_STATUS) begin
					avs_readdata_o <= {24'h0, exit_code_o, 1'b0, running_r, exit_flag_r, busy};
				end else if (avs_address_i == `VIPI_EXIT_LO) begin
					avs_readdata_o <= exit_detail_r[31:0];
				end else if (avs_address_i == `VIPI_EXIT_HI) begin
					avs_readdata_o <= exit_detail_r[63:32];
				end else begin
					avs_readdata_o <= `VIPI_RST_32;
				end
			end
			if (wr_acc) begin
				if (avs_address_i == `VIPI_CTRL) begin
					ctrl_r <= {1'b0, ctrl_m[1:0]};
				end else if (avs_address_i == `VIPI_OWN_ID) begin
					own_id_r <= own_m[8:0];
				end else if (avs_address_i == `VIPI_BACK_LO) begin
					ptr_back_r[31:0] <= merge(ptr_back_r[31:0], avs_writedata_i, avs_byteenable_i);
				end else if (avs_address_i == `VIPI_BACK_HI) begin
					ptr_back_r[51:32] <= back_m[19:0];
				end else if (avs_address_i == `VIPI_LOG_LO) begin
					ptr_log_r[31:0] <= merge(ptr_log_r[31:0], avs_writedata_i, avs_byteenable_i);
				end else if (avs_address_i == `VIPI_LOG_HI) begin
					ptr_log_r[51:32] <= log_m[19:0];
				end else if (avs_address_i == `VIPI_PHY_LO) begin
					ptr_phy_r[31:0] <= merge(ptr_phy_r[31:0], avs_writedata_i, avs_byteenable_i);
				end else if (avs_address_i == `VIPI_PHY_HI) begin
					ptr_phy_r[51:32] <= phy_m[19:0];
				end else if (avs_address_i == `VIPI_CMD_LO) begin
					cmd_lo_r <= merge(cmd_lo_r, avs_writedata_i, avs_byteenable_i);
				end else if (avs_address_i == `VIPI_CMD_HI) begin
					cmd_hi_r <= merge(cmd_hi_r, avs_writedata_i, avs_byteenable_i);
				end
			end
		end
	end

	// Delivery sequencer
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= S_IDLE;
			kind_r <= K_DIRECT;
			excl_r <= 1'b0;
			idx_r <= 9'h000;
			pos_r <= 4'h0;
			log_hi_r <= 1'b0;
			bp_r <= 40'h0;
			sched_r <= 1'b0;
			core_r <= 12'h000;
			unsched_r <= 1'b0;
			code_r <= `VIPI_EX_NONE;
			running_r <= 1'b0;
			exit_flag_r <= 1'b0;
			exit_detail_r <= 64'h0;
			exit_code_o <= `VIPI_EX_NONE;
			guest_exit_o <= 1'b0;
			db_valid_o <= 1'b0;
			db_self_o <= 1'b0;
			db_core_o <= 12'h000;
			mem_lock_o <= 1'b0;
			mp_start_r <= 1'b0;
			mp_we_r <= 1'b0;
			mp_addr_r <= 52'h0;
			mp_wdata_r <= 64'h0;
		end else begin
			mp_start_r <= 1'b0;
			guest_exit_o <= 1'b0;
			db_valid_o <= 1'b0;
			db_self_o <= 1'b0;
			exit_flag_r <= exit_flag_r && !clr_exit;
			case (state_r)
			S_IDLE: begin
				if (wr_enter) begin
					state_r <= S_ENTRY;
				end else if (wr_cmd && running_r) begin
					state_r <= S_DECODE;
				end
			end
			S_ENTRY: begin
				if (!ptr_ok(ptr_back_r) || !ptr_ok(ptr_log_r) || !ptr_ok(ptr_phy_r)) begin
					code_r <= `VIPI_EX_INVALID;
					state_r <= S_EXIT;
				end else if (max_idx > (reg_mode ? `VIPI_MAX_REGIF : `VIPI_MAX_MAPPED)) begin
					code_r <= `VIPI_EX_INVALID;
					state_r <= S_EXIT;
				end else begin
					running_r <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_DECODE: begin
				unsched_r <= 1'b0;
				excl_r <= (cmd_lo_r[19:18] == 2'b11);
				idx_r <= 9'h000;
				pos_r <= 4'h0;
				if (cmd_lo_r[10:8] != 3'h0 || cmd_lo_r[15]) begin
					code_r <= `VIPI_EX_UNSUP;
					state_r <= S_EXIT;
				end else if (cmd_lo_r[19:18] == 2'b01) begin
					kind_r <= K_SELF;
					bp_r <= ptr_back_r[51:12];
					state_r <= S_IRR_RD;
				end else if (cmd_lo_r[19:18] != 2'b00 ||
					(reg_mode ? (cmd_hi_r == 32'hffff_ffff) : (cmd_hi_r[31:24] == `VIPI_BCAST_ID))) begin
					kind_r <= K_BCAST;
					state_r <= S_PHY;
				end else if (cmd_lo_r[11]) begin
					kind_r <= K_LOGIC;
					state_r <= S_LOG;
				end else if (reg_mode && cmd_hi_r[31:9] != 23'h0) begin
					code_r <= `VIPI_EX_PHYSICAL;
					state_r <= S_EXIT;
				end else begin
					kind_r <= K_DIRECT;
					idx_r <= reg_mode ? cmd_hi_r[8:0] : {1'b0, cmd_hi_r[31:24]};
					state_r <= S_PHY;
				end
			end
			S_LOG: begin
				if (dg_bad) begin
					code_r <= `VIPI_EX_LOGICAL;
					state_r <= S_EXIT;
				end else if (!dg_hit) begin
					state_r <= S_NEXT;
				end else if (reg_mode) begin
					idx_r <= dg_phys;
					state_r <= S_PHY;
				end else begin
					mp_start_r <= 1'b1;
					mp_we_r <= 1'b0;
					mp_addr_r <= {ptr_log_r[51:12], dg_off[11:3], 3'b000};
					log_hi_r <= dg_off[2];
					state_r <= S_LOG_WAIT;
				end
			end
			S_LOG_WAIT: begin
				if (mp_done) begin
					if (!log_ent[`VIPI_LE_VALID] || log_ent[30:8] != 23'h0 ||
						log_ent[7:0] == `VIPI_BCAST_ID) begin
						code_r <= `VIPI_EX_LOGICAL;
						state_r <= S_EXIT;
					end else begin
						idx_r <= {1'b0, log_ent[7:0]};
						state_r <= S_PHY;
					end
				end
			end
			S_PHY: begin
				if (kind_r == K_BCAST && ((!reg_mode && idx_r == {1'b0, `VIPI_BCAST_ID}) ||
					(excl_r && idx_r == own_id_r))) begin
					state_r <= S_NEXT;
				end else if ({3'h0, idx_r} > max_idx) begin
					code_r <= `VIPI_EX_PHYSICAL;
					state_r <= S_EXIT;
				end else begin
					mp_start_r <= 1'b1;
					mp_we_r <= 1'b0;
					mp_addr_r <= {ptr_phy_r[51:12], idx_r, 3'b000};
					state_r <= S_PHY_WAIT;
				end
			end
			S_PHY_WAIT: begin
				if (mp_done) begin
					if (!mp_rdata[`VIPI_PE_INUSE]) begin
						if (kind_r == K_BCAST) begin
							state_r <= S_NEXT;
						end else begin
							code_r <= `VIPI_EX_PHYSICAL;
							state_r <= S_EXIT;
						end
					end else if (!ptr_ok({mp_rdata[51:12], 12'h000})) begin
						code_r <= `VIPI_EX_BACKING;
						state_r <= S_EXIT;
					end else begin
						bp_r <= mp_rdata[51:12];
						sched_r <= mp_rdata[`VIPI_PE_SCHED];
						core_r <= mp_rdata[`VIPI_PE_SCHED] ? mp_rdata[11:0] : 12'h000;
						state_r <= S_IRR_RD;
					end
				end
			end
			S_IRR_RD: begin
				mem_lock_o <= 1'b1;
				mp_start_r <= 1'b1;
				mp_we_r <= 1'b0;
				mp_addr_r <= {bp_r, irr_off};
				state_r <= S_IRR_WR;
			end
			S_IRR_WR: begin
				if (mp_done) begin
					mp_start_r <= 1'b1;
					mp_we_r <= 1'b1;
					mp_wdata_r <= mp_rdata | (64'h1 << vec[4:0]);
					state_r <= S_IRR_WAIT;
				end
			end
			S_IRR_WAIT: begin
				if (mp_done) begin
					mem_lock_o <= 1'b0;
					if (kind_r == K_SELF) begin
						db_self_o <= 1'b1;
						state_r <= S_IDLE;
					end else begin
						if (sched_r) begin
							db_valid_o <= 1'b1;
							db_core_o <= core_r;
						end else begin
							unsched_r <= 1'b1;
						end
						state_r <= S_NEXT;
					end
				end
			end
			S_NEXT: begin
				if (kind_r == K_BCAST) begin
					if ({3'h0, idx_r} >= max_idx) begin
						state_r <= S_FINISH;
					end else begin
						idx_r <= idx_r + 9'h001;
						state_r <= S_PHY;
					end
				end else if (kind_r == K_LOGIC && pos_r != 4'hf) begin
					pos_r <= pos_r + 4'h1;
					state_r <= S_LOG;
				end else begin
					state_r <= S_FINISH;
				end
			end
			S_FINISH: begin
				if (unsched_r) begin
					code_r <= `VIPI_EX_INCOMPLETE;
					state_r <= S_EXIT;
				end else begin
					state_r <= S_IDLE;
				end
			end
			S_EXIT: begin
				exit_flag_r <= 1'b1;
				exit_code_o <= code_r;
				exit_detail_r <= {cmd_hi_r, cmd_lo_r};
				guest_exit_o <= 1'b1;
				running_r <= 1'b0;
				mem_lock_o <= 1'b0;
				state_r <= S_IDLE;
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end
endmodule

/* File: vipi_map.vh */
`ifndef VIPI_MAP_VH
`define VIPI_MAP_VH
// Register byte offsets
`define VIPI_CTRL 6'h00
`define VIPI_OWN_ID 6'h04
`define VIPI_BACK_LO 6'h08
`define VIPI_BACK_HI 6'h0c
`define VIPI_LOG_LO 6'h10
`define VIPI_LOG_HI 6'h14
`define VIPI_PHY_LO 6'h18
`define VIPI_PHY_HI 6'h1c
`define VIPI_CMD_LO 6'h20
`define VIPI_CMD_HI 6'h24
`define VIPI_STATUS 6'h28
`define VIPI_EXIT_LO 6'h2c
`define VIPI_EXIT_HI 6'h30
// Control bits
`define VIPI_CTRL_REGMODE 0
`define VIPI_CTRL_CLUSTER 1
`define VIPI_CTRL_ENTER 2
// Status bits
`define VIPI_ST_BUSY 0
`define VIPI_ST_EXIT 1
`define VIPI_ST_RUNNING 2
// Exit codes
`define VIPI_EX_NONE 4'h0
`define VIPI_EX_INVALID 4'h1
`define VIPI_EX_INCOMPLETE 4'h2
`define VIPI_EX_LOGICAL 4'h3
`define VIPI_EX_UNSUP 4'h4
`define VIPI_EX_PHYSICAL 4'h5
`define VIPI_EX_BACKING 4'h6
// Table entry fields
`define VIPI_PE_INUSE 63
`define VIPI_PE_SCHED 62
`define VIPI_LE_VALID 31
// Limits and offsets
`define VIPI_MAX_MAPPED 12'h0ff
`define VIPI_MAX_REGIF 12'h1ff
`define VIPI_BCAST_ID 8'hff
`define VIPI_IRR_BASE 12'h200
`define VIPI_RST_32 32'h0000_0000
`endif

/* File: vipi_mem_port.v */
`timescale 1ns/1ps
module vipi_mem_port (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Request from sequencer
	input wire start_i,
	input wire we_i,
	input wire [51:0] addr_i,
	input wire [63:0] wdata_i,
	output reg done_o,
	output reg [63:0] rdata_o,
	// Memory side
	output reg mem_req_o,
	output reg mem_we_o,
	output reg [51:0] mem_addr_o,
	output reg [63:0] mem_wdata_o,
	input wire [63:0] mem_rdata_i,
	input wire mem_ack_i
);
	// Holds one request until the memory acknowledges it
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 52'h0;
			mem_wdata_o <= 64'h0;
			done_o <= 1'b0;
			rdata_o <= 64'h0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !mem_req_o) begin
				mem_req_o <= 1'b1;
				mem_we_o <= we_i;
				mem_addr_o <= addr_i;
				mem_wdata_o <= wdata_i;
			end else if (mem_req_o && mem_ack_i) begin
				mem_req_o <= 1'b0;
				done_o <= 1'b1;
				rdata_o <= mem_rdata_i;
			end
		end
	end
endmodule

/* File: vipi_dest_gen.v */
`timescale 1ns/1ps
module vipi_dest_gen (
	// Mode
	input wire reg_mode_i,
	input wire cluster_i,
	// Destination and step
	input wire [31:0] dest_i,
	input wire [3:0] pos_i,
	// Results
	output reg hit_o,
	output reg bad_o,
	output reg [11:0] log_off_o,
	output reg [8:0] phys_idx_o
);
	reg [15:0] lid_lo;
	always @* begin
		lid_lo = 16'h0001 << dest_i[3:0];
		hit_o = 1'b0;
		bad_o = 1'b0;
		log_off_o = 12'h000;
		phys_idx_o = {dest_i[8:4], pos_i};
		if (reg_mode_i) begin
			hit_o = lid_lo[pos_i];
			bad_o = |dest_i[19:9];
		end else if (cluster_i) begin
			hit_o = !pos_i[3] && !pos_i[2] && dest_i[24 + pos_i[1:0]];
			bad_o = (dest_i[31:28] == 4'hf);
			log_off_o = {4'h0, dest_i[31:28], pos_i[1:0], 2'b00};
		end else begin
			hit_o = !pos_i[3] && dest_i[24 + pos_i[2:0]];
			log_off_o = {7'h00, pos_i[2:0], 2'b00};
		end
	end
endmodule

/* File: vipi_delivery_properties.sv */
`timescale 1ns/1ps
module vipi_delivery_props (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Register bus
	input wire avs_read_i,
	input wire avs_waitrequest_o,
	// Memory
	input wire mem_req_o,
	input wire mem_we_o,
	input wire mem_lock_o,
	input wire [51:0] mem_addr_o,
	input wire [63:0] mem_wdata_o,
	input wire mem_ack_i,
	// Events
	input wire db_valid_o,
	input wire db_self_o,
	input wire guest_exit_o,
	input wire [3:0] exit_code_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Read and write halves of the request-bit update
	sequence irr_read_done;
		mem_lock_o && mem_req_o && mem_ack_i && !mem_we_o;
	endsequence
	sequence irr_write_done;
		mem_lock_o && mem_req_o && mem_ack_i && mem_we_o;
	endsequence
	rmw_locked_a: assert property (irr_read_done |=>
		mem_lock_o throughout (##[0:20] irr_write_done))
		else $error("request bit update not locked through its write");
	lock_end_a: assert property ($fell(mem_lock_o) |-> $past(mem_we_o, 2) && $past(mem_ack_i, 2))
		else $error("lock released without a completed write");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
		$stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
		else $error("memory request changed before acknowledge");
	req_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("memory request not released after acknowledge");
	word_align_a: assert property (mem_req_o |-> mem_addr_o[2:0] == 3'h0)
		else $error("memory address not word aligned");
	bell_pulse_a: assert property (db_valid_o |-> !mem_lock_o ##1 !db_valid_o)
		else $error("doorbell during locked update or longer than a cycle");
	self_stop_a: assert property (db_self_o |-> !db_valid_o ##1
		(!mem_req_o && !db_valid_o)[*3])
		else $error("delivery went on after self doorbell");
	exit_clean_a: assert property (guest_exit_o |-> !mem_lock_o && !mem_req_o &&
		exit_code_o != 4'h0 ##1 !guest_exit_o)
		else $error("exit raised with work pending or without code");
	read_wait_a: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("register read not answered after one wait cycle");
endmodule
bind vipi_delivery vipi_delivery_props vipi_delivery_props_i (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .avs_read_i(avs_read_i), .avs_waitrequest_o(avs_waitrequest_o),
	.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
	.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
	.db_valid_o(db_valid_o), .db_self_o(db_self_o), .guest_exit_o(guest_exit_o),
	.exit_code_o(exit_code_o));

/* File: vipi_mem_model.sv */
`timescale 1ns/1ps
module vipi_mem_model (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Latency select
	input wire slow_i,
	// Memory port
	input wire req_i,
	input wire we_i,
	input wire [51:0] addr_i,
	input wire [63:0] wdata_i,
	output logic [63:0] rdata_o,
	output logic ack_o
);
	// Sparse coherent untranslated store, no stale mapping after a core switch
	logic [63:0] mem [logic [48:0]];
	logic [2:0] cnt_r;
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			cnt_r <= 3'h0;
			rdata_o <= 64'h0;
		end else if (ack_o) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (we_i)
				mem[addr_i[51:3]] = wdata_i;
		end else if (req_i && cnt_r >= (slow_i ? 3'h3 : 3'h0)) begin
			ack_o <= 1'b1;
			cnt_r <= 3'h0;
			rdata_o <= mem.exists(addr_i[51:3]) ? mem[addr_i[51:3]] : 64'h0;
		end else if (req_i)
			cnt_r <= cnt_r + 3'h1;
	end
endmodule

/* File: vipi_delivery_test.sv */
`timescale 1ns/1ps
`include "vipi_map.vh"
module vipi_delivery_test;
	logic ref_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, slow_r;
	logic mem_req_o, mem_we_o, mem_lock_o, mem_ack_i, db_valid_o, db_self_o, guest_exit_o;
	logic [3:0] avs_byteenable_i, exit_code_o;
	logic [5:0] avs_address_i;
	logic [7:0] vec;
	logic [11:0] db_core_o;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [51:0] mem_addr_o;
	logic [63:0] mem_wdata_o, mem_rdata_i;
	logic [35:0] exp_q[$];
	logic [1:0] pe_flags[8] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h2, 2'h0, 2'h3, 2'h0};
	int failures, num_checks;
	localparam logic [51:0] own_bp = 52'h10000, log_bp = 52'h30000, phy_bp = 52'h20000;
	vipi_delivery vipi_delivery_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_lock_o(mem_lock_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i), .db_valid_o(db_valid_o), .db_core_o(db_core_o),
		.db_self_o(db_self_o), .guest_exit_o(guest_exit_o), .exit_code_o(exit_code_o));
	vipi_mem_model vipi_mem_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow_r),
		.req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 300);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
		if (n >= 300) begin
			failures++;
			end_of_test;
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, e);
	endtask
	task automatic ex(input logic [3:0] k, input logic [11:0] v);
		exp_q.push_back({k, 20'h0, v});
	endtask
	task automatic settle;
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && n < 400) begin
			bus(1'b0, `VIPI_STATUS, 32'h0, s);
			n++;
		end
		bus(1'b0, `VIPI_STATUS, 32'h0, s);
		if (n >= 400) begin
			failures++;
			end_of_test;
		end
		check(exp_q.size(), 0);
	endtask
	task automatic enter(input logic [31:0] ctrl, input logic [3:0] code);
		if (code != 4'h0)
			ex(4'h3, {8'h0, code});
		wr(`VIPI_CTRL, ctrl | 32'h4);
		settle;
	endtask
	task automatic cmd(input logic [31:0] hi, input logic [31:0] lo);
		logic [31:0] rnd;
		rnd = $urandom;
		slow_r <= rnd[0];
		vec = rnd[15:8];
		wr(`VIPI_CMD_HI, hi);
		wr(`VIPI_CMD_LO, lo | {24'h0, vec});
		settle;
	endtask
	task automatic take(input logic [35:0] seen);
		logic [35:0] e;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : 36'hf_ffff_ffff;
		check(seen, e);
	endtask
	function automatic logic [51:0] bp(input int i);
		return 52'h100000 + {28'h0, 12'(i), 12'h0};
	endfunction
	function automatic logic pending_request_bits(input logic [51:0] b, input logic [7:0] v);
		logic [51:0] a;
		a = b + 52'h200 + {45'h0, v[7:5], 4'h0};
		return vipi_mem_model_i.mem[a[51:3]][v[4:0]];
	endfunction
	always @(negedge ref_clk_i) begin
		if (rst_i === 1'b0) begin
			if (db_valid_o !== 1'b0)
				take({4'h1, 20'h0, db_core_o});
			if (db_self_o !== 1'b0)
				take({4'h2, 32'h0});
			if (guest_exit_o !== 1'b0)
				take({4'h3, 28'h0, exit_code_o});
		end
	end
	initial begin
		rst_i = 1'b1;
		{avs_read_i, avs_write_i, slow_r, avs_address_i, avs_writedata_i} = '0;
		avs_byteenable_i = 4'hf;
		failures = 0;
		num_checks = 0;
		void'($urandom(3));
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(`VIPI_CTRL, 32'h0);
		rd(6'h3c, 32'h0);
		for (int i = 0; i < 8; i++)
			vipi_mem_model_i.mem[phy_bp[51:3] + 49'(i)] = {pe_flags[i], 10'h0,
				bp(i) | {40'h0, 12'h5a0 + 12'(i)}};
		vipi_mem_model_i.mem[log_bp[51:3] + 49'h1] = 64'h8000_0003;
		vipi_mem_model_i.mem[log_bp[51:3] + 49'h2] = 64'h8000_0006_0000_0000;
		wr(`VIPI_BACK_LO, own_bp[31:0]);
		wr(`VIPI_LOG_LO, log_bp[31:0]);
		wr(`VIPI_PHY_LO, phy_bp[31:0] | 32'h100);
		enter(32'h0, 4'h1);
		enter(32'h1, 4'h0);
		wr(`VIPI_PHY_LO, phy_bp[31:0] | 32'h200);
		enter(32'h1, 4'h1);
		wr(`VIPI_PHY_LO, phy_bp[31:0] | 32'h7);
		wr(`VIPI_BACK_HI, 32'h10000);
		enter(32'h0, 4'h1);
		wr(`VIPI_BACK_HI, 32'h0);
		enter(32'h0, 4'h0);
		ex(4'h2, 12'h0);
		cmd(32'h0, 32'h4_0000);
		check(pending_request_bits(own_bp, vec), 1'b1);
		ex(4'h1, 12'h5a3);
		cmd(32'h0300_0000, 32'h0);
		check(pending_request_bits(bp(3), vec), 1'b1);
		ex(4'h1, 12'h5a2);
		ex(4'h1, 12'h5a2);
		wr(`VIPI_CMD_HI, 32'h0200_0000);
		wr(`VIPI_CMD_LO, 32'h0);
		cmd(32'h0200_0000, 32'h0);
		ex(4'h3, {8'h0, `VIPI_EX_INCOMPLETE});
		cmd(32'h0400_0000, 32'h0);
		check(pending_request_bits(bp(4), vec), 1'b1);
		rd(`VIPI_EXIT_LO, {24'h0, vec});
		rd(`VIPI_EXIT_HI, 32'h0400_0000);
		enter(32'h0, 4'h0);
		ex(4'h3, {8'h0, `VIPI_EX_PHYSICAL});
		cmd(32'h0500_0000, 32'h0);
		for (int s = 0; s < 3; s++) begin
			enter(32'h0, 4'h0);
			if (s != 2)
				ex(4'h1, 12'h5a0);
			ex(4'h1, 12'h5a2);
			ex(4'h1, 12'h5a3);
			ex(4'h1, 12'h5a6);
			ex(4'h3, {8'h0, `VIPI_EX_INCOMPLETE});
			cmd((s == 0) ? 32'hff00_0000 : 32'h0, (s == 0) ? 32'h0 : {12'h0, 2'(s + 1), 18'h0});
			check(pending_request_bits(bp(4), vec), 1'b1);
		end
		enter(32'h0, 4'h0);
		ex(4'h1, 12'h5a3);
		ex(4'h1, 12'h5a6);
		cmd(32'h2400_0000, 32'h800);
		ex(4'h3, {8'h0, `VIPI_EX_LOGICAL});
		cmd(32'h8000_0000, 32'h800);
		enter(32'h2, 4'h0);
		ex(4'h1, 12'h5a6);
		cmd(32'h1200_0000, 32'h800);
		ex(4'h3, {8'h0, `VIPI_EX_LOGICAL});
		cmd(32'hf100_0000, 32'h800);
		enter(32'h1, 4'h0);
		ex(4'h1, 12'h5a6);
		cmd(32'h6, 32'h0);
		ex(4'h1, 12'h5a3);
		cmd(32'h3, 32'h800);
		ex(4'h3, {8'h0, `VIPI_EX_UNSUP});
		cmd(32'h6, 32'h100);
		enter(32'h1, 4'h0);
		ex(4'h3, {8'h0, `VIPI_EX_UNSUP});
		cmd(32'h6, 32'h8000);
		end_of_test;
	end
endmodule
